// ---- rtl/panel_io_scanner.v ----
// Multiplexed panel I/O scanner: display, thumbwheel and keypad over AXI4-Lite
//
// Notes on behaviour
// - Select code 0-3 four digits, 4-7 eight digits; bits pick data/latch inversion.
// - Display busy flag high while the display driver runs.
// - Display round of four or eight digits takes 12 ticks, repeating.
// - First enabled run starts from the sequence start.
// - Four-digit reading in one word; eight digits use a second high word.
// - Digit count four or eight from setup bit, four by default.
// - Switch read round takes 12 ticks and restarts continuously.
// - Switch busy flag high while the switch reader runs.
// - Eight-digit result words split across areas raise the error flag.
// - Bad input or output unit assignment raises the error flag.
// - Switch output bit 5 goes high after a complete round.
// - Keypad shift register of eight hex digits, new digit enters low.
// - Held key sets its bit in held word and output bit 4.
// - While one key is held, other keys are ignored.
// - Each key digit captured within 4 ticks, then scanning resumes after release.
// - Keypad busy flag high while the keypad scanner runs.
// - Keypad register words split across areas raise the error flag.
// - Display data on bits 0-3, strobes 4-7; bit 8 or 12 after round.
// - Eight-digit display takes low digits from source, high from next word.
`timescale 1ns/100ps
`include "panel_io_map.vh"
module panel_io_scanner (
	core_clk,
	rstn,
	s_axi_awaddr,
	s_axi_awvalid,
	s_axi_awready,
	s_axi_wdata,
	s_axi_wstrb,
	s_axi_wvalid,
	s_axi_wready,
	s_axi_bresp,
	s_axi_bvalid,
	s_axi_bready,
	s_axi_araddr,
	s_axi_arvalid,
	s_axi_arready,
	s_axi_rdata,
	s_axi_rresp,
	s_axi_rvalid,
	s_axi_rready,
	sw_in,
	key_in,
	disp_out,
	sw_out,
	key_out,
	display_busy_flag,
	switch_read_busy_flag,
	keypad_busy_flag,
	instruction_error_flag
);
	input  wire        core_clk;
	input  wire        rstn;
	input  wire [7:0]  s_axi_awaddr;
	input  wire        s_axi_awvalid;
	output wire        s_axi_awready;
	input  wire [31:0] s_axi_wdata;
	input  wire [3:0]  s_axi_wstrb;
	input  wire        s_axi_wvalid;
	output wire        s_axi_wready;
	output reg  [1:0]  s_axi_bresp;
	output reg         s_axi_bvalid;
	input  wire        s_axi_bready;
	input  wire [7:0]  s_axi_araddr;
	input  wire        s_axi_arvalid;
	output wire        s_axi_arready;
	output reg  [31:0] s_axi_rdata;
	output reg  [1:0]  s_axi_rresp;
	output reg         s_axi_rvalid;
	input  wire        s_axi_rready;
	input  wire [15:0] sw_in;
	input  wire [3:0]  key_in;
	output reg  [15:0] disp_out;
	output reg  [15:0] sw_out;
	output wire [4:0]  key_out;
	output wire        display_busy_flag;
	output wire        switch_read_busy_flag;
	output wire        keypad_busy_flag;
	output wire        instruction_error_flag;

	reg  [31:0] ctrl_reg;
	reg  [31:0] disp_src_reg;
	reg  [31:0] disp_src_hi_reg;
	reg  [31:0] tick_div_reg;
	reg  [31:0] tick_cnt_reg;
	reg         tick_reg;
	reg  [15:0] sw_result_reg;
	reg  [15:0] sw_res_hi_reg;
	reg  [15:0] sw_acc_lo_reg;
	reg  [15:0] sw_acc_hi_reg;
	reg  [7:0]  aw_addr_reg;
	reg         aw_full_reg;
	reg  [31:0] w_data_reg;
	reg  [3:0]  w_strb_reg;
	reg         w_full_reg;
	reg  [31:0] rd_next;
	reg         rd_ok;
	reg         wr_ok;
	reg  [3:0]  nib;
	reg  [2:0]  digit;

	wire        disp_en   = ctrl_reg[`CTRL_DISP_EN];
	wire        sw_en     = ctrl_reg[`CTRL_SW_EN];
	wire        key_en    = ctrl_reg[`CTRL_KEY_EN];
	wire        sw_eight  = ctrl_reg[`CTRL_SW_EIGHT];
	wire [2:0]  disp_sel  = ctrl_reg[`CTRL_SEL_HI:`CTRL_SEL_LO];
	wire        disp_eight = disp_sel[2];
	wire        data_inv  = disp_sel[1];
	wire        latch_inv = disp_sel[0];
	wire [3:0]  disp_step;
	wire        disp_wrap;
	wire [3:0]  sw_step;
	wire        sw_wrap;
	wire [15:0] key_lo;
	wire [15:0] key_hi;
	wire [15:0] key_held;
	wire        do_wr;

	// ----------------------------------------
	// Scan-cycle tick generator
	// ----------------------------------------
	// Tick period is software set so panel latches see slow, settled data
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			tick_cnt_reg <= 32'h0000_0000;
			tick_reg     <= 1'b0;
		end else if (tick_cnt_reg >= tick_div_reg) begin
			tick_cnt_reg <= 32'h0000_0000;
			tick_reg     <= 1'b1;
		end else begin
			tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
			tick_reg     <= 1'b0;
		end
	end

	// ----------------------------------------
	// Sequencers
	// ----------------------------------------
	bcd_stepper disp_seq (
		.core_clk (core_clk),
		.rstn     (rstn),
		.en       (disp_en),
		.tick     (tick_reg),
		.step     (disp_step),
		.wrap     (disp_wrap)
	);

	bcd_stepper sw_seq (
		.core_clk (core_clk),
		.rstn     (rstn),
		.en       (sw_en),
		.tick     (tick_reg),
		.step     (sw_step),
		.wrap     (sw_wrap)
	);

	key_matrix keypad (
		.core_clk  (core_clk),
		.rstn      (rstn),
		.en        (key_en),
		.tick      (tick_reg),
		.key_in    (key_in),
		.drive_out (key_out),
		.shift_lo  (key_lo),
		.shift_hi  (key_hi),
		.held_word (key_held)
	);

	// ----------------------------------------
	// Display digit select
	// ----------------------------------------
	// Steps 0-7 strobe digits, 8-11 idle; four-digit mode uses steps 0-3 only
	always @* begin
		digit = disp_step[2:0];
		case (digit[1:0])
			2'd0: nib = digit[2] ? disp_src_hi_reg[3:0] : disp_src_reg[3:0];
			2'd1: nib = digit[2] ? disp_src_hi_reg[7:4] : disp_src_reg[7:4];
			2'd2: nib = digit[2] ? disp_src_hi_reg[11:8] : disp_src_reg[11:8];
			default: nib = digit[2] ? disp_src_hi_reg[15:12] : disp_src_reg[15:12];
		endcase
	end

	// ----------------------------------------
	// Display driver outputs
	// ----------------------------------------
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			disp_out <= 16'h0000;
		end else if (disp_en && tick_reg) begin
			disp_out <= 16'h0000;
			if (!disp_step[3] && (disp_eight || !disp_step[2])) begin
				disp_out[3:0] <= nib ^ {4{data_inv}};
				disp_out[7:4] <= (4'b0001 << disp_step[1:0]) ^ {4{latch_inv}};
				disp_out[11:8] <= disp_eight ? ({3'b000, disp_step[2]} ^ {4{latch_inv}}) : 4'h0; // Block select, eight only
			end else begin
				disp_out[7:0] <= {{4{latch_inv}}, {4{data_inv}}};
			end
			if (disp_wrap) begin
				disp_out[8]  <= !disp_eight;
				disp_out[12] <= disp_eight;
			end
		end
	end

	// ----------------------------------------
	// Thumbwheel switch reader
	// ----------------------------------------
	// Steps 0-3 (or 0-7) select a digit on bits 0-3, data sampled one step later
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			sw_out        <= 16'h0000;
			sw_acc_lo_reg <= 16'h0000;
			sw_acc_hi_reg <= 16'h0000;
			sw_result_reg <= 16'h0000;
			sw_res_hi_reg <= 16'h0000;
		end else if (sw_en && tick_reg) begin
			sw_out <= 16'h0000;
			if (sw_step < (sw_eight ? 4'd8 : 4'd4)) begin
				sw_out[3:0] <= 4'b0001 << sw_step[1:0];
				sw_out[4]   <= sw_step[2];
			end
			if (sw_step != 4'd0 && sw_step <= (sw_eight ? 4'd8 : 4'd4)) begin
				if (sw_step > 4'd4) begin
					sw_acc_hi_reg <= {sw_in[3:0], sw_acc_hi_reg[15:4]};
				end else begin
					sw_acc_lo_reg <= {sw_in[3:0], sw_acc_lo_reg[15:4]};
				end
			end
			if (sw_wrap) begin
				sw_result_reg <= sw_acc_lo_reg;
				sw_res_hi_reg <= sw_eight ? sw_acc_hi_reg : 16'h0000;
				sw_out[5]     <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Busy and error flags
	// ----------------------------------------
	assign display_busy_flag     = disp_en;
	assign switch_read_busy_flag = sw_en;
	assign keypad_busy_flag      = key_en;
	// Area checks reduce to software-set split bits, no data memory here
	assign instruction_error_flag = (disp_en && disp_eight && ctrl_reg[`CTRL_DISP_SPLIT])
		| (sw_en && sw_eight && ctrl_reg[`CTRL_SW_SPLIT])
		| (sw_en && ctrl_reg[`CTRL_SW_IO_BAD])
		| (key_en && ctrl_reg[`CTRL_KEY_SPLIT]);

	// ----------------------------------------
	// AXI4-Lite write channel
	// ----------------------------------------
	assign s_axi_awready = !aw_full_reg && !s_axi_bvalid;
	assign s_axi_wready  = !w_full_reg && !s_axi_bvalid;
	assign do_wr = aw_full_reg && w_full_reg && !s_axi_bvalid;

	always @* begin
		case (aw_addr_reg)
			`OFS_CTRL, `OFS_DISP_SRC, `OFS_DISP_SRC_HI, `OFS_TICK_DIV: wr_ok = 1'b1;
			default: wr_ok = 1'b0;
		endcase
	end

	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			aw_addr_reg     <= 8'h00;
			aw_full_reg     <= 1'b0;
			w_data_reg      <= 32'h0000_0000;
			w_strb_reg      <= 4'h0;
			w_full_reg      <= 1'b0;
			s_axi_bvalid    <= 1'b0;
			s_axi_bresp     <= 2'b00;
			ctrl_reg        <= `CTRL_RESET;
			disp_src_reg    <= 32'h0000_0000;
			disp_src_hi_reg <= 32'h0000_0000;
			tick_div_reg    <= `TICK_DIV_RESET;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_addr_reg <= {s_axi_awaddr[7:2], 2'b00};
				aw_full_reg <= 1'b1;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
				w_full_reg <= 1'b1;
			end
			if (do_wr) begin
				aw_full_reg  <= 1'b0;
				w_full_reg   <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_ok ? 2'b00 : 2'b10;
				case (aw_addr_reg)
					`OFS_CTRL:        ctrl_reg        <= w_data_reg;
					`OFS_DISP_SRC:    disp_src_reg    <= w_data_reg;
					`OFS_DISP_SRC_HI: disp_src_hi_reg <= w_data_reg;
					`OFS_TICK_DIV:    tick_div_reg    <= w_data_reg;
					default:          ;
				endcase
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// AXI4-Lite read channel
	// ----------------------------------------
	assign s_axi_arready = !s_axi_rvalid;

	always @* begin
		rd_ok = 1'b1;
		case ({s_axi_araddr[7:2], 2'b00})
			`OFS_CTRL:         rd_next = ctrl_reg;
			`OFS_DISP_SRC:     rd_next = disp_src_reg;
			`OFS_DISP_SRC_HI:  rd_next = disp_src_hi_reg;
			`OFS_SW_RESULT:    rd_next = {16'h0000, sw_result_reg};
			`OFS_SW_RES_HI:    rd_next = {16'h0000, sw_res_hi_reg};
			`OFS_KEY_SHIFT:    rd_next = {16'h0000, key_lo};
			`OFS_KEY_SHIFT_HI: rd_next = {16'h0000, key_hi};
			`OFS_KEY_HELD:     rd_next = {16'h0000, key_held};
			`OFS_STATUS:       rd_next = {28'h000_0000, instruction_error_flag, switch_read_busy_flag,
				display_busy_flag, keypad_busy_flag};
			`OFS_SW_IN:        rd_next = {16'h0000, sw_in};
			`OFS_KEY_IN:       rd_next = {28'h000_0000, key_in};
			`OFS_DISP_OUT:     rd_next = {16'h0000, disp_out};
			`OFS_SW_OUT:       rd_next = {16'h0000, sw_out};
			`OFS_KEY_OUT:      rd_next = {27'h000_0000, key_out};
			`OFS_TICK_DIV:     rd_next = tick_div_reg;
			default: begin
				rd_next = 32'h0000_0000;
				rd_ok   = 1'b0;
			end
		endcase
	end

	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= 2'b00;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_next;
			s_axi_rresp  <= rd_ok ? 2'b00 : 2'b10;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule // panel_io_scanner

// ---- rtl/panel_io_map.vh ----
// Constants for the multiplexed panel I/O scanner
`ifndef PANEL_IO_MAP_VH
`define PANEL_IO_MAP_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_CTRL        8'h00
`define OFS_DISP_SRC    8'h04
`define OFS_DISP_SRC_HI 8'h08
`define OFS_SW_RESULT   8'h0C
`define OFS_SW_RES_HI   8'h10
`define OFS_KEY_SHIFT   8'h14
`define OFS_KEY_SHIFT_HI 8'h18
`define OFS_KEY_HELD    8'h1C
`define OFS_STATUS      8'h20
`define OFS_SW_IN       8'h24
`define OFS_KEY_IN      8'h28
`define OFS_DISP_OUT    8'h2C
`define OFS_SW_OUT      8'h30
`define OFS_KEY_OUT     8'h34
`define OFS_TICK_DIV    8'h38

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define CTRL_DISP_EN    0
`define CTRL_SW_EN      1
`define CTRL_KEY_EN     2
`define CTRL_SW_EIGHT   3
`define CTRL_SEL_LO     4
`define CTRL_SEL_HI     6
`define CTRL_DISP_SPLIT 8
`define CTRL_SW_SPLIT   9
`define CTRL_KEY_SPLIT  10
`define CTRL_SW_IO_BAD  11

// ----------------------------------------
// Status register fields
// ----------------------------------------
`define ST_KEY_BUSY     0
`define ST_DISP_BUSY    1
`define ST_SW_BUSY      2
`define ST_INSTR_ERR    3

// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define CTRL_RESET      32'h0000_0000
`define TICK_DIV_RESET  32'h0000_03E8
`define ROUND_STEPS     4'hC
`define KEY_MIN_STEPS   4'h3

`endif

// ---- rtl/bcd_stepper.v ----
// Round step counter used by the display driver and switch reader
`timescale 1ns/100ps
`include "panel_io_map.vh"
module bcd_stepper (
	core_clk,
	rstn,
	en,
	tick,
	step,
	wrap
);
	input  wire       core_clk;
	input  wire       rstn;
	input  wire       en;
	input  wire       tick;
	output reg  [3:0] step;
	output wire       wrap;

	// ----------------------------------------
	// Step counter
	// ----------------------------------------
	// Last step of the round; restart follows on the next tick
	assign wrap = (step == `ROUND_STEPS - 4'h1);

	// Counter cleared while disabled so a fresh enable starts at step 0
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			step <= 4'h0;
		end else if (!en) begin
			step <= 4'h0;
		end else if (tick) begin
			step <= wrap ? 4'h0 : step + 4'h1;
		end
	end
endmodule // bcd_stepper

// ---- rtl/key_matrix.v ----
// Hex keypad matrix scanner with shift register and held-key word
`timescale 1ns/100ps
module key_matrix (
	core_clk,
	rstn,
	en,
	tick,
	key_in,
	drive_out,
	shift_lo,
	shift_hi,
	held_word
);
	input  wire        core_clk;
	input  wire        rstn;
	input  wire        en;
	input  wire        tick;
	input  wire [3:0]  key_in;
	output reg  [4:0]  drive_out;
	output reg  [15:0] shift_lo;
	output reg  [15:0] shift_hi;
	output reg  [15:0] held_word;

	reg  [1:0] row_reg;
	reg  [1:0] lock_col_reg;
	reg        lock_reg;
	reg  [1:0] col_hit;
	reg        any_hit;
	wire [3:0] code;

	// ----------------------------------------
	// Column encode, lowest set input wins
	// ----------------------------------------
	always @* begin
		any_hit = |key_in;
		col_hit = key_in[0] ? 2'd0 : key_in[1] ? 2'd1 : key_in[2] ? 2'd2 : 2'd3;
	end

	assign code = {row_reg, col_hit};

	// ----------------------------------------
	// Row scan and key capture, one step per tick
	// ----------------------------------------
	// A held key locks its row so other keys are not seen until release
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			row_reg      <= 2'd0;
			lock_col_reg <= 2'd0;
			lock_reg     <= 1'b0;
			drive_out    <= 5'h00;
			shift_lo     <= 16'h0000;
			shift_hi     <= 16'h0000;
			held_word    <= 16'h0000;
		end else if (en && tick) begin
			if (lock_reg) begin
				if (!key_in[lock_col_reg]) begin
					lock_reg  <= 1'b0;
					held_word <= 16'h0000;
					drive_out <= {1'b0, 4'b0001 << row_reg};
				end
			end else if (any_hit) begin
				lock_reg     <= 1'b1;
				lock_col_reg <= col_hit;
				// New digit into the low nibble, top digit dropped
				{shift_hi, shift_lo} <= {shift_hi[11:0], shift_lo, code};
				held_word    <= 16'h0001 << code;
				drive_out    <= {1'b1, drive_out[3:0]};
			end else begin
				// Next row; a full pass is 4 ticks, so capture lands within 4 ticks
				row_reg   <= row_reg + 2'd1;
				drive_out <= {1'b0, 4'b0001 << (row_reg + 2'd1)};
			end
		end
	end
endmodule // key_matrix

// ---- tb/panel_io_scanner_sva.sv ----
// Concurrent checks on the panel I/O scanner ports
`timescale 1ns/100ps
module panel_io_scanner_sva (
	input wire logic        core_clk,
	input wire logic        rstn,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic [15:0] disp_out,
	input wire logic [15:0] sw_out,
	input wire logic [4:0]  key_out,
	input wire logic        display_busy_flag,
	input wire logic        switch_read_busy_flag,
	input wire logic        keypad_busy_flag,
	input wire logic        instruction_error_flag
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);
	// ---------------------------------------------
	// Steps
	// ---------------------------------------------
	sequence wr_both;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence rd_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	// Bench runs a 3-cycle tick, so one tick is three samples
	sequence one_tick_high;
		sw_out[5] [*2] ##1 !sw_out[5];
	endsequence
	// ---------------------------------------------
	// Properties
	// ---------------------------------------------
	wr_answer_a: assert property (wr_both |=> ##1 s_axi_bvalid)
		else $error("write response missing");
	rd_answer_a: assert property (rd_take |=> s_axi_rvalid)
		else $error("read data missing");
	rd_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address taken while data pending");
	busy_cause_a: assert property (
		$changed({display_busy_flag, switch_read_busy_flag, keypad_busy_flag, instruction_error_flag})
		|-> ##[0:1] s_axi_bvalid) else $error("flag moved without a write");
	disp_freeze_a: assert property (
		!display_busy_flag && !$past(display_busy_flag) |-> $stable(disp_out)) else $error("display moved while off");
	sw_freeze_a: assert property (
		!switch_read_busy_flag && !$past(switch_read_busy_flag) |-> $stable(sw_out)) else $error("switch moved while off");
	key_freeze_a: assert property (
		!keypad_busy_flag && !$past(keypad_busy_flag) |-> $stable(key_out)) else $error("keypad moved while off");
	sw_pace_a: assert property ($changed(sw_out) |=> $stable(sw_out) [*2])
		else $error("switch outputs changed between ticks");
	done_pulse_a: assert property ($rose(sw_out[5]) && switch_read_busy_flag |=> one_tick_high)
		else $error("round done not one tick long");
endmodule // panel_io_scanner_sva

bind panel_io_scanner panel_io_scanner_sva u_panel_io_scanner_sva (.core_clk(core_clk), .rstn(rstn),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .disp_out(disp_out), .sw_out(sw_out),
	.key_out(key_out), .display_busy_flag(display_busy_flag), .switch_read_busy_flag(switch_read_busy_flag),
	.keypad_busy_flag(keypad_busy_flag), .instruction_error_flag(instruction_error_flag));

// ---- tb/panel_far_side.sv ----
// Far-side panel model: thumbwheel switch bank and hex keypad matrix
`timescale 1ns/100ps
module panel_far_side (
	input  wire logic [15:0] sw_out,
	input  wire logic [4:0]  key_out,
	input  wire logic [31:0] set_value,
	input  wire logic [3:0]  key_a,
	input  wire logic        key_a_down,
	input  wire logic [3:0]  key_b,
	input  wire logic        key_b_down,
	output logic      [15:0] sw_in,
	output logic      [3:0]  key_in
);
	logic [2:0] pick;
	logic       hit;
	// Selected digit drives lines 0-3; no select reads as open contacts
	// No input filter is modelled, so it is always shorter than a tick
	always_comb begin
		pick = 3'b000;
		hit = 1'b0;
		for (int i = 0; i < 4; i++) if (sw_out[3:0] == (4'b0001 << i)) begin
			pick = {sw_out[4], i[1:0]};
			hit = 1'b1;
		end
		sw_in = {12'h000, hit ? set_value[4 * pick +: 4] : 4'h0};
	end
	// Key joins its driven row to its column; code is row times four plus column
	always_comb begin
		key_in = (key_a_down && key_out[key_a[3:2]]) ? (4'b0001 << key_a[1:0]) : 4'h0;
		if (key_b_down && key_out[key_b[3:2]]) key_in = key_in | (4'b0001 << key_b[1:0]);
	end
endmodule // panel_far_side

// ---- tb/test_panel_io_scanner.sv ----
// Self-checking bench for the panel I/O scanner
`timescale 1ns/100ps
`include "panel_io_map.vh"
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module test_panel_io_scanner;
	localparam int TICK = 3; // Tick divider set to 2
	logic        core_clk = 1'b0, rstn = 1'b0;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0000_0000, set_value = 32'h0000_0000;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, key_a_down = 1'b0, key_b_down = 1'b0;
	logic [3:0]  s_axi_wstrb = 4'hf, key_a = 4'h0, key_b = 4'h0, key_in, lat;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
	logic [31:0] s_axi_rdata, seed = 32'h0000_d124, src, sv, ks, d, hs, ex;
	logic [15:0] sw_in, disp_out, sw_out;
	logic [4:0]  key_out;
	logic        display_busy_flag, switch_read_busy_flag, keypad_busy_flag, instruction_error_flag;
	logic        watch = 1'b0;
	logic [2:0]  wcode = 3'b000;
	int          n_mismatch = 0, samples_checked = 0, cycles = 0, n;
	panel_io_scanner u_panel_io_scanner (.core_clk(core_clk), .rstn(rstn), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .sw_in(sw_in), .key_in(key_in), .disp_out(disp_out), .sw_out(sw_out),
		.key_out(key_out), .display_busy_flag(display_busy_flag), .switch_read_busy_flag(switch_read_busy_flag),
		.keypad_busy_flag(keypad_busy_flag), .instruction_error_flag(instruction_error_flag));
	panel_far_side u_panel_far_side (.sw_out(sw_out), .key_out(key_out), .set_value(set_value), .key_a(key_a),
		.key_a_down(key_a_down), .key_b(key_b), .key_b_down(key_b_down), .sw_in(sw_in), .key_in(key_in));
	// ---------------------------------------------
	// Clock, timeout and verdict
	// ---------------------------------------------
	always #2 core_clk = ~core_clk;
	// Cut a hang short well past the expected run length
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_mismatch++;
			give_verdict();
		end
	end
	task give_verdict;
		$display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// ---------------------------------------------
	// Helpers
	// ---------------------------------------------
	function automatic logic [31:0] lfsr_next();
		for (int i = 0; i < 32; i++) seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed;
	endfunction
	function automatic logic [31:0] bcd(input logic [31:0] x);
		for (int i = 0; i < 8; i++) bcd[4 * i +: 4] = x[4 * i +: 4] % 10;
	endfunction
	// Address and data offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge core_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		`CHK("bresp", er, s_axi_bresp)
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge core_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge core_clk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		while (!s_axi_rvalid) @(posedge core_clk);
		d = s_axi_rdata;
		rr = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string nm);
		rd(a);
		`CHK(nm, e, d)
	endtask
	// Cycles until a display (0-15) or switch (16-31) output bit rises
	task automatic rise(input int b, output int cnt);
		logic p, c;
		cnt = 0;
		c = b < 16 ? disp_out[b] : sw_out[b - 16];
		do begin
			p = c;
			@(posedge core_clk);
			c = b < 16 ? disp_out[b] : sw_out[b - 16];
			cnt++;
		end while (!(c && !p) && cnt < 300);
	endtask
	// Digit under an active strobe must equal its source nibble
	always @(posedge core_clk) if (watch) begin
		lat = disp_out[7:4] ^ {4{wcode[0]}};
		ex = (wcode[2] && (disp_out[8] ^ wcode[0])) ? hs : src; // Block select picks the high word
		for (int i = 0; i < 4; i++) if (lat == (4'b0001 << i)) `CHK("digit", ex[4 * i +: 4], disp_out[3:0] ^ {4{wcode[1]}})
	end
	// ---------------------------------------------
	// Main sequence
	// ---------------------------------------------
	initial begin
		repeat (4) @(posedge core_clk);
		rstn <= 1'b1;
		`CHK("disp reset", 16'h0000, disp_out)
		rchk(`OFS_CTRL, `CTRL_RESET, "ctrl reset");
		rchk(`OFS_TICK_DIV, `TICK_DIV_RESET, "div reset");
		rd(8'h3c);
		`CHK("unmapped", 2'b10, rr)
		wr(`OFS_STATUS, 32'h0000_000f, 2'b10);
		rchk(`OFS_STATUS, 32'h0000_0000, "status ro");
		wr(`OFS_TICK_DIV, 32'h0000_0002, 2'b00);
		// Busy flags follow the enables, error bits one by one
		wr(`OFS_CTRL, 32'h0000_0007, 2'b00);
		`CHK("busy", 3'b111, {display_busy_flag, switch_read_busy_flag, keypad_busy_flag})
		rchk(`OFS_STATUS, 32'h0000_0007, "status busy");
		for (int b = 8; b < 12; b++) begin
			// Each error bit needs its own enables (and eight-digit mode for the display and switch split checks)
			n = (b == 8) ? 32'h0000_0041 : (b == 9) ? 32'h0000_000a : (b == 10) ? 32'h0000_0004 : 32'h0000_0002;
			wr(`OFS_CTRL, (32'h0000_0001 << b) | n, 2'b00);
			`CHK("err", 1'b1, instruction_error_flag)
			rchk(`OFS_STATUS, 32'h0000_0008 | ((b == 8) ? 32'h0000_0002 : (b == 10) ? 32'h0000_0001 : 32'h0000_0004),
				"status err");
		end
		// Every select code; restart and round length measured
		for (int k = 0; k < 8; k++) begin
			src = bcd(lfsr_next());
			wr(`OFS_DISP_SRC, src, 2'b00);
			hs = bcd(lfsr_next());
			wr(`OFS_DISP_SRC_HI, hs, 2'b00);
			wr(`OFS_CTRL, 32'h0000_0001 | (k << 4), 2'b00);
			rise(k < 4 ? 8 : 12, n);
			`CHK("first round", 1'b1, n >= 28 && n <= 40)
			wcode = k;
			watch = 1'b1;
			rise(k < 4 ? 8 : 12, n);
			watch = 1'b0;
			`CHK("disp round", TICK * `ROUND_STEPS, n)
			wr(`OFS_CTRL, 32'h0000_0000, 2'b00);
		end
		// Switch: four digits by default, then eight
		sv = bcd(lfsr_next());
		set_value <= sv;
		for (int m = 0; m < 2; m++) begin
			wr(`OFS_CTRL, 32'h0000_0002 | (m << 3), 2'b00);
			rise(21, n);
			rise(21, n);
			`CHK("sw round", TICK * `ROUND_STEPS, n)
			rise(21, n); // Extra round of margin
			rchk(`OFS_SW_RESULT, sv[15:0], "sw low");
			if (m == 1) rchk(`OFS_SW_RES_HI, sv[31:16], "sw high");
		end
		// Keypad: ten keys overflow the shift register; one second key ignored
		wr(`OFS_CTRL, 32'h0000_0004, 2'b00);
		ks = 32'h0000_0000;
		for (int j = 0; j < 10; j++) begin
			src = lfsr_next();
			key_a <= src[3:0];
			key_a_down <= 1'b1;
			n = 0;
			do begin
				@(posedge core_clk);
				n++;
			end while (!key_out[4] && n < 100);
			`CHK("key time", 1'b1, n <= TICK * 12 + TICK)
			ks = {ks[27:0], src[3:0]};
			rchk(`OFS_KEY_HELD, 32'h0000_0001 << src[3:0], "held");
			if (j == 5) begin
				key_b <= src[3:0] ^ 4'h1;
				key_b_down <= 1'b1;
				repeat (40) @(posedge core_clk);
				rchk(`OFS_KEY_HELD, 32'h0000_0001 << src[3:0], "other key");
			end
			key_a_down <= 1'b0;
			key_b_down <= 1'b0;
			repeat (40) @(posedge core_clk);
			`CHK("key free", 1'b0, key_out[4])
			rchk(`OFS_KEY_SHIFT, ks[15:0], "shift lo");
			rchk(`OFS_KEY_SHIFT_HI, ks[31:16], "shift hi");
		end
		give_verdict();
	end
endmodule // test_panel_io_scanner
